// ===== rtl/teqi_core.sv
// Touch event qualifier: blocking, pattern detection and alert
`timescale 1ns/100ps
module teqi_core (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire teqi_pkg::teqi_chan_t [5:0] chan_in,
  input wire logic [7:0] standby_th,
  input wire logic cycle_done,
  input wire logic [5:0] repeat_tick,
  input wire logic release_irq_enable,
  input wire teqi_pkg::teqi_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  output logic alert_b,
  output logic [5:0] touch_status,
  output logic multi_touch_flag,
  output logic pattern_event_flag
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] pattern_member_reg;
  logic [7:0] touch_irq_enable_reg;
  logic [7:0] repeat_enable_reg;
  logic [7:0] multi_touch_config_reg;
  logic [7:0] pattern_detect_config_reg;
  logic [5:0] accepted_reg;
  logic pattern_cond_reg;
  logic int_reg;
  logic multi_reg;
  logic pat_flag_reg;
  logic alert_b_reg;
  logic [7:0] rdata_reg;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire wr_ctrl = reg_req.wr_en && reg_req.addr == teqi_pkg::ADDR_CTRL;
  wire wr_pat = reg_req.wr_en && reg_req.addr == teqi_pkg::ADDR_PATTERN;
  wire wr_ien = reg_req.wr_en && reg_req.addr == teqi_pkg::ADDR_IRQ_EN;
  wire wr_rpt = reg_req.wr_en && reg_req.addr == teqi_pkg::ADDR_RPT_EN;
  wire wr_mt = reg_req.wr_en && reg_req.addr == teqi_pkg::ADDR_MT_CFG;
  wire wr_pd = reg_req.wr_en && reg_req.addr == teqi_pkg::ADDR_PD_CFG;

  wire blk_en = multi_touch_config_reg[teqi_pkg::MT_BLK_BIT];
  wire [1:0] lim_code =
    multi_touch_config_reg[teqi_pkg::MT_LIM_LSB +: 2];
  wire [2:0] limit = {1'b0, lim_code} + 3'h1;
  wire pd_en = pattern_detect_config_reg[teqi_pkg::PD_EN_BIT];
  wire [1:0] frac_sel =
    pattern_detect_config_reg[teqi_pkg::PD_TH_LSB +: 2];
  wire pd_cmp = pattern_detect_config_reg[teqi_pkg::PD_CMP_BIT];
  wire pd_irq = pattern_detect_config_reg[teqi_pkg::PD_IRQ_BIT];
  wire [5:0] pattern = pattern_member_reg[5:0];

  // ----------------------------------------------------------------
  // Per-input qualification chains
  // ----------------------------------------------------------------
  logic [5:0] touch_raw;
  logic [5:0] above;
  logic [5:0] kept;
  logic [5:0] take;
  logic [2:0] kcnt [0:6];
  logic [2:0] acnt [0:6];
  logic [2:0] abv_cnt [0:6];
  logic [2:0] pat_cnt [0:6];

  assign kcnt[0] = 3'h0;
  assign abv_cnt[0] = 3'h0;
  assign pat_cnt[0] = 3'h0;
  assign acnt[0] = kcnt[6];

  genvar gi;
  generate
    for (gi = 0; gi < teqi_pkg::NUM_CH; gi++) begin : g_ch
      logic [7:0] th;
      logic [7:0] pth;
      assign touch_raw[gi] = chan_in[gi].touch;
      assign th = chan_in[gi].standby ? standby_th : chan_in[gi].active_th;
      assign pth = (frac_sel == teqi_pkg::FRAC_12P5) ? {3'h0, th[7:3]} :
                   (frac_sel == teqi_pkg::FRAC_25) ? {2'h0, th[7:2]} :
                   (frac_sel == teqi_pkg::FRAC_37P5) ?
                   ({2'h0, th[7:2]} + {3'h0, th[7:3]}) : th;
      assign above[gi] = (chan_in[gi].delta > pth) | chan_in[gi].noise;
      // keep accepted inputs, then fill in scan order
      // A lowered limit trims held touches in scan order as well
      assign kept[gi] = accepted_reg[gi] & touch_raw[gi] &
                        (kcnt[gi] < limit);
      assign kcnt[gi+1] = kcnt[gi] + {2'h0, kept[gi]};
      assign take[gi] = touch_raw[gi] & ~kept[gi] & (acnt[gi] < limit);
      assign acnt[gi+1] = acnt[gi] + {2'h0, take[gi]};
      assign abv_cnt[gi+1] = abv_cnt[gi] + {2'h0, above[gi]};
      assign pat_cnt[gi+1] = pat_cnt[gi] + {2'h0, pattern[gi]};
    end
  endgenerate

  // ----------------------------------------------------------------
  // Pattern condition and touch acceptance
  // ----------------------------------------------------------------
  // An empty pattern would match every cycle and lock out all touches
  wire pat_exact = (above & pattern) == pattern;
  wire pat_count = abv_cnt[6] >= pat_cnt[6];
  // enable gate; exact mode; count mode
  wire pcond_next = pd_en && (pattern != 6'h00) &&
                    (pd_cmp ? pat_exact : pat_count);
  wire [5:0] acc_next = pcond_next ? 6'h00 :
                        (blk_en ? (kept | take) : touch_raw);
  wire over = blk_en && !pcond_next && |(touch_raw & ~acc_next);

  // ----------------------------------------------------------------
  // Interrupt sources
  // ----------------------------------------------------------------
  wire [5:0] onset = {6{cycle_done}} & acc_next & ~accepted_reg;
  wire [5:0] rel = {6{cycle_done & release_irq_enable & ~pcond_next}} &
                   ~acc_next & accepted_reg;
  // ticks ignored without repeat; held touch repeats
  wire [5:0] rpt = repeat_tick & repeat_enable_reg[5:0] & accepted_reg;
  // per-input gate; bit i serves input i
  wire [5:0] ch_irq = (onset | rel | rpt) & touch_irq_enable_reg[5:0];
  wire pat_evt = cycle_done && pcond_next && !pattern_cond_reg;
  wire int_set = (|ch_irq) || (pat_evt && pd_irq);
  wire int_clr = wr_ctrl && !reg_req.wdata[teqi_pkg::CTRL_INT_BIT];
  wire int_next = int_set || (int_reg && !int_clr);
  // clear only once the condition is gone
  wire pat_flag_next = pat_evt ||
                       (pat_flag_reg && !(int_clr && !pattern_cond_reg));
  wire multi_next = (cycle_done && over) || (multi_reg && !int_clr);
  wire pcond_hold = cycle_done ? pcond_next : pattern_cond_reg;
  wire [5:0] acc_hold = cycle_done ? acc_next : accepted_reg;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // unused bits read zero
  wire [7:0] status_rd = {6'h00, pat_flag_reg, multi_reg};
  wire [7:0] rd_mux =
    (reg_req.addr == teqi_pkg::ADDR_CTRL) ? {7'h00, int_reg} :
    (reg_req.addr == teqi_pkg::ADDR_STATUS) ? status_rd :
    (reg_req.addr == teqi_pkg::ADDR_TOUCH) ? {2'h0, accepted_reg} :
    (reg_req.addr == teqi_pkg::ADDR_PATTERN) ? pattern_member_reg :
    (reg_req.addr == teqi_pkg::ADDR_IRQ_EN) ? touch_irq_enable_reg :
    (reg_req.addr == teqi_pkg::ADDR_RPT_EN) ? repeat_enable_reg :
    (reg_req.addr == teqi_pkg::ADDR_MT_CFG) ? multi_touch_config_reg :
    (reg_req.addr == teqi_pkg::ADDR_PD_CFG) ? pattern_detect_config_reg :
    8'h00;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // writes masked to defined bits
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pattern_member_reg <= teqi_pkg::RST_PATTERN;
      touch_irq_enable_reg <= teqi_pkg::RST_IRQ_EN;
      repeat_enable_reg <= teqi_pkg::RST_RPT_EN;
      multi_touch_config_reg <= teqi_pkg::RST_MT_CFG;
      pattern_detect_config_reg <= teqi_pkg::RST_PD_CFG;
    end else begin
      if (wr_pat) pattern_member_reg <= reg_req.wdata & teqi_pkg::MASK_CH;
      if (wr_ien) touch_irq_enable_reg <= reg_req.wdata & teqi_pkg::MASK_CH;
      if (wr_rpt) repeat_enable_reg <= reg_req.wdata & teqi_pkg::MASK_CH;
      if (wr_mt) multi_touch_config_reg <=
        reg_req.wdata & teqi_pkg::MASK_MT_CFG;
      if (wr_pd) pattern_detect_config_reg <=
        reg_req.wdata & teqi_pkg::MASK_PD_CFG;
    end
  end

  // ----------------------------------------------------------------
  // Event state
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      accepted_reg <= 6'h00;
      pattern_cond_reg <= 1'b0;
      int_reg <= 1'b0;
      multi_reg <= 1'b0;
      pat_flag_reg <= 1'b0;
      alert_b_reg <= 1'b1;
      rdata_reg <= 8'h00;
    end else begin
      // blocking follows the condition on each cycle_done
      accepted_reg <= acc_hold;
      pattern_cond_reg <= pcond_hold;
      int_reg <= int_next;
      multi_reg <= multi_next;
      pat_flag_reg <= pat_flag_next;
      alert_b_reg <= !int_next;
      rdata_reg <= rd_mux;
    end
  end

  assign reg_rdata = rdata_reg;
  assign alert_b = alert_b_reg;
  assign touch_status = accepted_reg;
  assign multi_touch_flag = multi_reg;
  assign pattern_event_flag = pat_flag_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence pat_clear_s;
    int_clr && !pattern_cond_reg && !pat_evt;
  endsequence

  sequence pat_alert_s;
    pat_evt && pd_irq;
  endsequence

  touch_alert_a: assert property (
    (|(onset & touch_irq_enable_reg[5:0])) |=> !alert_b)
    else $error("enabled touch did not assert alert");
  masked_quiet_a: assert property (
    (touch_irq_enable_reg == 8'h00 && !pd_irq && !int_reg) |=> alert_b)
    else $error("alert asserted with all sources masked");
  no_repeat_a: assert property (
    (!int_reg && !cycle_done && !(|(repeat_tick & repeat_enable_reg[5:0])))
    |=> !int_reg)
    else $error("interrupt raised without a qualifying source");
  hold_repeat_a: assert property (
    (|(repeat_tick & repeat_enable_reg[5:0] & accepted_reg &
       touch_irq_enable_reg[5:0])) |=> !alert_b)
    else $error("repeat tick on held touch gave no alert");
  no_block_a: assert property (
    (cycle_done && !blk_en && !pcond_next) |=>
    touch_status == $past(touch_raw))
    else $error("touch suppressed with blocking disabled");
  touch_limit_a: assert property (
    (cycle_done && blk_en) |-> acnt[6] <= limit)
    else $error("accepted touches exceed the limit");
  multi_flag_a: assert property (
    (cycle_done && over) |=> multi_touch_flag [*1])
    else $error("multiple-touch flag not set on blocking");
  pat_disabled_a: assert property (
    (cycle_done && !pd_en) |=> !pattern_cond_reg)
    else $error("pattern condition while detection disabled");
  pat_block_a: assert property (
    pattern_cond_reg |-> touch_status == 6'h00)
    else $error("touch reported during pattern block");
  pat_hold_a: assert property (
    (pattern_event_flag && pattern_cond_reg) |=> pattern_event_flag)
    else $error("pattern flag dropped while condition holds");
  pat_clear_a: assert property (
    pat_clear_s |=> !pattern_event_flag)
    else $error("pattern flag not cleared after condition ended");
  pat_alert_a: assert property (
    pat_alert_s |=> (!alert_b && pattern_event_flag))
    else $error("pattern event did not raise alert");
  pat_quiet_a: assert property (
    (pat_evt && !pd_irq && !int_reg && !(|ch_irq)) |=>
    (alert_b && pattern_event_flag))
    else $error("masked pattern event asserted alert");
  release_alert_a: assert property (
    (|(rel & touch_irq_enable_reg[5:0])) |=> !alert_b)
    else $error("enabled release did not assert alert");
  no_block_multi_a: assert property (
    (cycle_done && !blk_en && !multi_touch_flag) |=> !multi_touch_flag)
    else $error("multiple-touch flag set with blocking disabled");
  kept_hold_a: assert property (
    (cycle_done && blk_en) |=> (touch_status & ~$past(touch_raw)) == 6'h00)
    else $error("blocked input reported without a touch");
  alert_clear_a: assert property (
    (int_clr && !(|ch_irq) && !pat_evt) |=> alert_b)
    else $error("alert stayed low after interrupt clear");
  reserved_zero_a: assert property (
    pattern_member_reg[7:6] == 2'h0 &&
    touch_irq_enable_reg[7:6] == 2'h0 &&
    repeat_enable_reg[7:6] == 2'h0 &&
    (multi_touch_config_reg & ~teqi_pkg::MASK_MT_CFG) == 8'h00 &&
    (pattern_detect_config_reg & ~teqi_pkg::MASK_PD_CFG) == 8'h00)
    else $error("reserved configuration bits not zero");

endmodule : teqi_core

// ===== rtl/teqi_pkg.sv
// Constants and carrier types for the touch event qualifier
package teqi_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int NUM_CH = 6;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h02;
  localparam logic [7:0] ADDR_TOUCH = 8'h03;
  localparam logic [7:0] ADDR_PATTERN = 8'h20;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h27;
  localparam logic [7:0] ADDR_RPT_EN = 8'h28;
  localparam logic [7:0] ADDR_MT_CFG = 8'h2a;
  localparam logic [7:0] ADDR_PD_CFG = 8'h2b;

  // ----------------------------------------------------------------
  // Reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_PATTERN = 8'h3f;
  localparam logic [7:0] RST_IRQ_EN = 8'h3f;
  localparam logic [7:0] RST_RPT_EN = 8'h3f;
  localparam logic [7:0] RST_MT_CFG = 8'h80;
  localparam logic [7:0] RST_PD_CFG = 8'h00;
  localparam logic [7:0] MASK_CH = 8'h3f;
  localparam logic [7:0] MASK_MT_CFG = 8'h8c;
  localparam logic [7:0] MASK_PD_CFG = 8'h8f;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MT_BLK_BIT = 7;
  localparam int MT_LIM_LSB = 2;
  localparam int PD_EN_BIT = 7;
  localparam int PD_TH_LSB = 2;
  localparam int PD_CMP_BIT = 1;
  localparam int PD_IRQ_BIT = 0;
  localparam int CTRL_INT_BIT = 0;
  localparam int STAT_MULTI_BIT = 0;
  localparam int STAT_PAT_BIT = 1;

  // Pattern threshold fraction codes
  localparam logic [1:0] FRAC_12P5 = 2'h0;
  localparam logic [1:0] FRAC_25 = 2'h1;
  localparam logic [1:0] FRAC_37P5 = 2'h2;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic touch;
    logic noise;
    logic standby;
    logic [7:0] delta;
    logic [7:0] active_th;
  } teqi_chan_t;

  typedef struct packed {
    logic [7:0] addr;
    logic wr_en;
    logic [7:0] wdata;
  } teqi_reg_req_t;

endpackage : teqi_pkg

// ===== tb/teqi_host_model.sv
// Host processor model driving the register request port
`timescale 1ns/100ps
module teqi_host_model (
  input wire logic sys_clk,
  output teqi_pkg::teqi_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata
);
  initial reg_req = '0;

  // ----------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------
  // Strobe is held across exactly one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_req <= '{addr: a, wr_en: 1'b1, wdata: d};
    @(negedge sys_clk);
    reg_req.wr_en <= 1'b0;
  endtask : wr

  // Read data lands one edge after the address is shown
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    reg_req <= '{addr: a, wr_en: 1'b0, wdata: 8'h00};
    @(negedge sys_clk);
    d = reg_rdata;
  endtask : rd

  task automatic clear_int();
    wr(teqi_pkg::ADDR_CTRL, 8'h00);
  endtask : clear_int
endmodule : teqi_host_model

// ===== tb/teqi_core_test.sv
// Self-checking bench for the touch event qualifier core
`timescale 1ns/100ps
module teqi_core_test;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  teqi_pkg::teqi_chan_t [5:0] chan_in = '0;
  logic [7:0] standby_th = 8'h28;
  logic cycle_done = 1'b0;
  logic [5:0] repeat_tick = 6'h00;
  logic release_irq_enable = 1'b0;
  logic sb = 1'b0;
  teqi_pkg::teqi_reg_req_t reg_req;
  logic [7:0] reg_rdata;
  logic alert_b;
  logic [5:0] touch_status;
  logic multi_touch_flag;
  logic pattern_event_flag;
  logic [7:0] th;
  int mismatches = 0;
  int cmp_count = 0;
  logic [7:0] ra [5] = '{8'h20, 8'h27, 8'h28, 8'h2a, 8'h2b};
  logic [7:0] rr [5] = '{8'h3f, 8'h3f, 8'h3f, 8'h80, 8'h00};
  logic [7:0] rm [5] = '{8'h3f, 8'h3f, 8'h3f, 8'h8c, 8'h8f};

  always #4 sys_clk = ~sys_clk;

  teqi_core u_teqi_core (
    .sys_clk(sys_clk), .rst_b(rst_b), .chan_in(chan_in),
    .standby_th(standby_th), .cycle_done(cycle_done),
    .repeat_tick(repeat_tick), .release_irq_enable(release_irq_enable),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .alert_b(alert_b),
    .touch_status(touch_status), .multi_touch_flag(multi_touch_flag),
    .pattern_event_flag(pattern_event_flag)
  );
  teqi_host_model u_teqi_host_model (
    .sys_clk(sys_clk), .reg_req(reg_req), .reg_rdata(reg_rdata)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [5:0] oh(input int i);
    return 6'(1 << i);
  endfunction : oh

  task automatic chk(input string nm, input logic [7:0] seen,
    input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_teqi_host_model.rd(a, d);
    chk($sformatf("reg %h", a), d, e);
  endtask : rc

  task automatic w(input logic [7:0] a, input logic [7:0] d);
    u_teqi_host_model.wr(a, d);
  endtask : w

  // Extra edge lets the registered alert settle after the clear
  task automatic clr();
    u_teqi_host_model.clear_int();
    @(negedge sys_clk);
  endtask : clr

  // One sensing cycle; inputs in h show delta d, the rest zero
  task automatic sense(input logic [5:0] t, input logic [5:0] h,
    input logic [7:0] d, input logic [5:0] n);
    @(negedge sys_clk);
    for (int i = 0; i < 6; i++) begin
      chan_in[i] <= '{t[i], n[i], sb, h[i] ? d : 8'h00, 8'h50};
    end
    cycle_done <= 1'b1;
    @(negedge sys_clk);
    cycle_done <= 1'b0;
  endtask : sense

  task automatic touch(input logic [5:0] t);
    sense(t, 6'h00, 8'h00, 6'h00);
  endtask : touch

  task automatic tick(input logic [5:0] t);
    @(negedge sys_clk);
    repeat_tick <= t;
    @(negedge sys_clk);
    repeat_tick <= 6'h00;
    @(negedge sys_clk);
  endtask : tick

  task automatic ev(input logic [5:0] h, input logic [7:0] d,
    input logic [5:0] n, input logic e);
    sense(6'h01, h, d, n);
    chk("pattern flag", 8'(pattern_event_flag), 8'(e));
  endtask : ev

  task automatic rel();
    touch(6'h01);
    clr();
  endtask : rel

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    #100000;
    mismatches++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_b <= 1'b1;
    chk("alert idle", 8'(alert_b), 8'h01);
    foreach (ra[i]) begin
      rc(ra[i], rr[i]);
      w(ra[i], 8'hff);
      rc(ra[i], rm[i]);
      w(ra[i], rr[i]);
    end
    rc(8'h10, 8'h00);
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      w(8'h27, 8'(oh(i)));
      touch(oh((i + 1) % 6));
      chk("alert masked", 8'(alert_b), 8'h01);
      touch(6'h00);
      touch(oh(i));
      chk("touch status", 8'(touch_status), 8'(oh(i)));
      chk("alert enabled", 8'(alert_b), 8'h00);
      rc(8'h00, 8'h01);
      rc(8'h03, 8'(oh(i)));
      touch(6'h00);
      clr();
      chk("alert cleared", 8'(alert_b), 8'h01);
    end
    $display("test enables done");
    w(8'h27, 8'h01);
    release_irq_enable <= 1'b1;
    for (int r = 0; r < 2; r++) begin
      w(8'h28, 8'(r));
      touch(6'h01);
      chk("touch alert", 8'(alert_b), 8'h00);
      clr();
      tick(6'h01);
      chk("repeat alert", 8'(alert_b), 8'(1 - r));
      clr();
      touch(6'h00);
      chk("release alert", 8'(alert_b), 8'h00);
      clr();
    end
    release_irq_enable <= 1'b0;
    $display("test repeat done");
    w(8'h27, 8'h00);
    for (int k = 0; k < 4; k++) begin
      w(8'h2a, 8'h80 | 8'(k << 2));
      touch(6'h3f);
      chk("limit", 8'(touch_status), 8'((1 << (k + 1)) - 1));
      chk("multi flag", 8'(multi_touch_flag), 8'h01);
      rc(8'h02, 8'h01);
      touch(6'h00);
      clr();
    end
    w(8'h2a, 8'h80);
    touch(6'h04);
    touch(6'h3f);
    chk("kept", 8'(touch_status), 8'h04);
    touch(6'h3b);
    chk("scan order", 8'(touch_status), 8'h01);
    touch(6'h00);
    clr();
    w(8'h2a, 8'h0c);
    touch(6'h3f);
    chk("no block", 8'(touch_status), 8'h3f);
    chk("no multi", 8'(multi_touch_flag), 8'h00);
    touch(6'h00);
    w(8'h2a, 8'h80);
    $display("test blocking done");
    w(8'h20, 8'h03);
    w(8'h2b, 8'h03);
    ev(6'h03, 8'hff, 6'h00, 1'b0);
    rel();
    for (int f = 0; f < 4; f++) begin
      th = (f == 3) ? 8'h50 : 8'(10 * (f + 1));
      w(8'h2b, 8'h82 | 8'(f << 2) | 8'(f % 2));
      ev(6'h03, th, 6'h00, 1'b0);
      ev(6'h03, th + 8'h01, 6'h00, 1'b1);
      chk("blocked", 8'(touch_status), 8'h00);
      chk("pattern alert", 8'(alert_b), 8'(1 - f % 2));
      touch(6'h01);
      chk("restored", 8'(touch_status), 8'h01);
      chk("flag held", 8'(pattern_event_flag), 8'h01);
      rc(8'h02, 8'h02);
      clr();
      chk("flag cleared", 8'(pattern_event_flag), 8'h00);
      chk("alert off", 8'(alert_b), 8'h01);
    end
    w(8'h2b, 8'h82);
    ev(6'h05, 8'hff, 6'h00, 1'b0);
    ev(6'h01, 8'hff, 6'h02, 1'b1);
    rel();
    w(8'h2b, 8'h80);
    ev(6'h04, 8'hff, 6'h00, 1'b0);
    ev(6'h05, 8'hff, 6'h00, 1'b1);
    rel();
    sb = 1'b1;
    w(8'h2b, 8'h82);
    ev(6'h03, 8'h05, 6'h00, 1'b0);
    ev(6'h03, 8'h06, 6'h00, 1'b1);
    rel();
    $display("test pattern done");
    tally_and_finish();
  end
endmodule : teqi_core_test
